// ### hw/tpe_regs.vh
// Purpose: Register offsets, field positions and reset values of the transmit
//          errored-packet insertion and transmit monitoring counter block.
// Assumes: 8-bit register port with byte addresses as listed below.
// Notes:   Definitions only.
`ifndef TPE_REGS_VH
`define TPE_REGS_VH

// ==========================================================================
// Register offsets
`define TPE_ADDR_W 8
`define TPE_OFS_TX_CTRL_LOW 8'hc4
`define TPE_OFS_ERRPKT_COUNT 8'hc6
`define TPE_OFS_ERRPKT_RATE 8'hc7
`define TPE_OFS_ERRINS_DONE_STATUS 8'hc8
`define TPE_OFS_ERRINS_DONE_LATCHED 8'hc9
`define TPE_OFS_ERRINS_DONE_IRQ_ENABLE 8'hca
`define TPE_OFS_TX_PACKET_COUNT_B0 8'hcc
`define TPE_OFS_TX_PACKET_COUNT_B1 8'hcd
`define TPE_OFS_TX_PACKET_COUNT_B2 8'hce
`define TPE_OFS_TX_BYTE_COUNT_B0 8'hd0
`define TPE_OFS_TX_BYTE_COUNT_B1 8'hd1
`define TPE_OFS_TX_BYTE_COUNT_B2 8'hd2
`define TPE_OFS_TX_BYTE_COUNT_B3 8'hd3
`define TPE_OFS_MANUAL_ERROR_INSERT 8'hd4
`define TPE_OFS_TX_MONITOR_UPDATE 8'hd6
`define TPE_OFS_TX_MONITOR_UPDATE_STATUS 8'hd7

// ==========================================================================
// Field positions
`define TPE_BIT_INITIATE 0
`define TPE_BIT_MODE_SEL 7
`define TPE_BIT_FLAG 0
`define TPE_RATE_X_HI 3
`define TPE_RATE_X_LO 0
`define TPE_RATE_Y_HI 6
`define TPE_RATE_Y_LO 4

// ==========================================================================
// Values
`define TPE_RST_BYTE 8'h00
`define TPE_TOTAL_CONTINUOUS 8'hff
`define TPE_RATE_Y_MAX 3'h6

`endif

// ### hw/tpe_tx_errins.v
// Purpose: Transmit errored-packet insertion sequencer, manual single error
//          insertion and transmit packet/byte monitoring counters.
// Assumes: Events from the transmit packet processor arrive on ref_clk as
//          one-cycle pulses; register port is synchronous to ref_clk.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "tpe_regs.vh"

module tpe_tx_errins #(
   parameter PKT_CNT_W = 24,
   parameter BYTE_CNT_W = 32
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Transmit path events
   input wire pkt_sent,
   input wire byte_sent,
   // Transmit path error control
   output reg auto_err_pkt,
   output reg manual_err,
   // Interrupt
   output wire irq
);

   // =======================================================================
   // Helpers
   // Powers of ten for the rate exponent; codes six and seven share the cap
   function [23:0] pow10;
      input [2:0] y;
      begin
         case (y)
            3'h0: pow10 = 24'h000001;
            3'h1: pow10 = 24'h00000a;
            3'h2: pow10 = 24'h000064;
            3'h3: pow10 = 24'h0003e8;
            3'h4: pow10 = 24'h002710;
            3'h5: pow10 = 24'h0186a0;
            default: pow10 = 24'h0f4240;
         endcase
      end
   endfunction

   // Register strobe decode; every register write uses wr_hit, rd_hit only the latched flag read
   function wr_hit;
      input [7:0] addr;
      input [7:0] ofs;
      input wr;
      begin
         wr_hit = wr && (addr == ofs);
      end
   endfunction

   function rd_hit;
      input [7:0] addr;
      input [7:0] ofs;
      input rd;
      begin
         rd_hit = rd && (addr == ofs);
      end
   endfunction

   // =======================================================================
   // Control registers
   reg [7:0] errored_packet_count_ctrl_q;
   reg [7:0] errored_packet_rate_ctrl_q;
   reg errins_finished_irq_en_q;
   reg manual_single_error_q;
   reg monitor_update_request_q;

   wire initiate_wr;
   wire [3:0] rate_x;
   wire [2:0] rate_y;
   wire manual_insert_mode_sel;

   // Initiate is a strobe, not a register, so nothing is stored for it
   assign initiate_wr = wr_hit(reg_addr, `TPE_OFS_TX_CTRL_LOW, reg_wr) &&
                        reg_wdata[`TPE_BIT_INITIATE];
   assign rate_x = errored_packet_rate_ctrl_q[`TPE_RATE_X_HI:`TPE_RATE_X_LO];
   assign rate_y = errored_packet_rate_ctrl_q[`TPE_RATE_Y_HI:`TPE_RATE_Y_LO];
   assign manual_insert_mode_sel = errored_packet_rate_ctrl_q[`TPE_BIT_MODE_SEL];

   // Spare bits of the one-bit registers are not stored and read as zero
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         errored_packet_count_ctrl_q <= `TPE_RST_BYTE;
         errored_packet_rate_ctrl_q <= `TPE_RST_BYTE;
         errins_finished_irq_en_q <= 1'b0;
         manual_single_error_q <= 1'b0;
         monitor_update_request_q <= 1'b0;
      end else begin
         if (wr_hit(reg_addr, `TPE_OFS_ERRPKT_COUNT, reg_wr)) begin
            errored_packet_count_ctrl_q <= reg_wdata;
         end
         if (wr_hit(reg_addr, `TPE_OFS_ERRPKT_RATE, reg_wr)) begin
            errored_packet_rate_ctrl_q <= reg_wdata;
         end
         if (wr_hit(reg_addr, `TPE_OFS_ERRINS_DONE_IRQ_ENABLE, reg_wr)) begin
            errins_finished_irq_en_q <= reg_wdata[`TPE_BIT_FLAG];
         end
         if (wr_hit(reg_addr, `TPE_OFS_MANUAL_ERROR_INSERT, reg_wr)) begin
            manual_single_error_q <= reg_wdata[`TPE_BIT_FLAG];
         end
         if (wr_hit(reg_addr, `TPE_OFS_TX_MONITOR_UPDATE, reg_wr)) begin
            monitor_update_request_q <= reg_wdata[`TPE_BIT_FLAG];
         end
      end
   end

   // =======================================================================
   // Automatic errored-packet insertion
   reg active_q;
   reg [23:0] period_cnt_q;
   reg [7:0] inserted_q;
   reg errins_finished_q;
   reg errins_finished_latched_q;

   wire [23:0] period;
   wire ins_disabled;
   wire period_hit;
   wire [7:0] inserted_next;
   wire latched_rd;

   // x is at most 15 and 10^y at most 10^6, so the product fits in 24 bits
   assign period = rate_x * pow10(rate_y);
   assign ins_disabled = (rate_x == 4'h0);
   // At or above one less than the period, so lowering the rate mid-run cannot overrun
   assign period_hit = (period_cnt_q >= period - 24'h000001);
   assign inserted_next = inserted_q + 8'h01;
   assign latched_rd = rd_hit(reg_addr, `TPE_OFS_ERRINS_DONE_LATCHED, reg_rd);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         active_q <= 1'b0;
         period_cnt_q <= 24'h000000;
         inserted_q <= 8'h00;
         errins_finished_q <= 1'b0;
         auto_err_pkt <= 1'b0;
      end else begin
         auto_err_pkt <= 1'b0;
         if (initiate_wr) begin
            active_q <= 1'b1;
            period_cnt_q <= 24'h000000;
            inserted_q <= 8'h00;
            errins_finished_q <= 1'b0;
         end else if (ins_disabled) begin
            active_q <= 1'b0;
            period_cnt_q <= 24'h000000;
            errins_finished_q <= 1'b0;
         end else if (active_q && pkt_sent) begin
            if (period_hit) begin
               auto_err_pkt <= 1'b1;
               period_cnt_q <= 24'h000000;
               if (errored_packet_count_ctrl_q != `TPE_TOTAL_CONTINUOUS) begin
                  inserted_q <= inserted_next;
                  if (inserted_next >= errored_packet_count_ctrl_q) begin
                     active_q <= 1'b0;
                     errins_finished_q <= 1'b1;
                  end
               end
            end else begin
               period_cnt_q <= period_cnt_q + 24'h000001;
            end
         end
      end
   end

   // Latched flag: a fresh rise in the read cycle wins over the clear
   reg finished_prev_q;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         finished_prev_q <= 1'b0;
         errins_finished_latched_q <= 1'b0;
      end else begin
         finished_prev_q <= errins_finished_q;
         if (errins_finished_q && !finished_prev_q) begin
            errins_finished_latched_q <= 1'b1;
         end else if (latched_rd) begin
            errins_finished_latched_q <= 1'b0;
         end
      end
   end

   assign irq = errins_finished_latched_q && errins_finished_irq_en_q;

   // =======================================================================
   // Manual single error insertion
   reg manual_prev_q;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         manual_prev_q <= 1'b0;
         manual_err <= 1'b0;
      end else begin
         manual_prev_q <= manual_single_error_q;
         // Independent of the automatic sequence, which keeps running
         manual_err <= manual_single_error_q && !manual_prev_q &&
                       manual_insert_mode_sel;
      end
   end

   // =======================================================================
   // Monitoring counters and snapshot
   // Running counters wrap silently; software must update often enough
   reg [PKT_CNT_W-1:0] pkt_run_q;
   reg [BYTE_CNT_W-1:0] byte_run_q;
   reg [PKT_CNT_W-1:0] sent_packet_count_q;
   reg [BYTE_CNT_W-1:0] sent_byte_count_q;
   reg update_prev_q;
   reg update_pend_q;
   reg monitor_update_done_q;

   wire update_rise;

   assign update_rise = monitor_update_request_q && !update_prev_q;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pkt_run_q <= {PKT_CNT_W{1'b0}};
         byte_run_q <= {BYTE_CNT_W{1'b0}};
         sent_packet_count_q <= {PKT_CNT_W{1'b0}};
         sent_byte_count_q <= {BYTE_CNT_W{1'b0}};
         update_prev_q <= 1'b0;
         update_pend_q <= 1'b0;
         monitor_update_done_q <= 1'b0;
      end else begin
         update_prev_q <= monitor_update_request_q;
         if (update_rise) begin
            // An event in the snapshot cycle seeds the new count, so none is lost
            sent_packet_count_q <= pkt_run_q;
            sent_byte_count_q <= byte_run_q;
            pkt_run_q <= {{(PKT_CNT_W-1){1'b0}}, pkt_sent};
            byte_run_q <= {{(BYTE_CNT_W-1){1'b0}}, byte_sent};
         end else begin
            // Snapshots are only written above, so multi-byte reads stay coherent
            if (pkt_sent) begin
               pkt_run_q <= pkt_run_q + {{(PKT_CNT_W-1){1'b0}}, 1'b1};
            end
            if (byte_sent) begin
               byte_run_q <= byte_run_q + {{(BYTE_CNT_W-1){1'b0}}, 1'b1};
            end
         end
         // Done follows the snapshot by one cycle so software never sees it early
         update_pend_q <= update_rise;
         if (!monitor_update_request_q) begin
            monitor_update_done_q <= 1'b0;
         end else if (update_pend_q) begin
            monitor_update_done_q <= 1'b1;
         end
      end
   end

   // =======================================================================
   // Read data
   // Zero-extend without a replication, which would be empty at full width
   reg [31:0] pkt_ext;
   reg [31:0] byte_ext;
   reg [7:0] rdata_d;
   wire [7:0] pkt_lane [0:2];
   wire [7:0] byte_lane [0:3];
   genvar lane;

   always @* begin
      pkt_ext = 32'h00000000;
      pkt_ext[PKT_CNT_W-1:0] = sent_packet_count_q;
   end

   always @* begin
      byte_ext = 32'h00000000;
      byte_ext[BYTE_CNT_W-1:0] = sent_byte_count_q;
   end

   generate
      for (lane = 0; lane < 3; lane = lane + 1) begin : g_pkt_lane
         assign pkt_lane[lane] = pkt_ext[8*lane +: 8];
      end
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_byte_lane
         assign byte_lane[lane] = byte_ext[8*lane +: 8];
      end
   endgenerate

   // Decode is combinational; only the registered copy reaches the port
   always @* begin
      case (reg_addr)
         // Initiate bit has no stored state and reads zero
         `TPE_OFS_TX_CTRL_LOW: rdata_d = 8'h00;
         `TPE_OFS_ERRPKT_COUNT: rdata_d = errored_packet_count_ctrl_q;
         `TPE_OFS_ERRPKT_RATE: rdata_d = errored_packet_rate_ctrl_q;
         `TPE_OFS_ERRINS_DONE_STATUS: rdata_d = {7'h00, errins_finished_q};
         `TPE_OFS_ERRINS_DONE_LATCHED: rdata_d = {7'h00, errins_finished_latched_q};
         `TPE_OFS_ERRINS_DONE_IRQ_ENABLE: rdata_d = {7'h00, errins_finished_irq_en_q};
         // Snapshot bytes, lowest byte at the lowest address
         `TPE_OFS_TX_PACKET_COUNT_B0: rdata_d = pkt_lane[0];
         `TPE_OFS_TX_PACKET_COUNT_B1: rdata_d = pkt_lane[1];
         `TPE_OFS_TX_PACKET_COUNT_B2: rdata_d = pkt_lane[2];
         `TPE_OFS_TX_BYTE_COUNT_B0: rdata_d = byte_lane[0];
         `TPE_OFS_TX_BYTE_COUNT_B1: rdata_d = byte_lane[1];
         `TPE_OFS_TX_BYTE_COUNT_B2: rdata_d = byte_lane[2];
         `TPE_OFS_TX_BYTE_COUNT_B3: rdata_d = byte_lane[3];
         `TPE_OFS_MANUAL_ERROR_INSERT: rdata_d = {7'h00, manual_single_error_q};
         `TPE_OFS_TX_MONITOR_UPDATE: rdata_d = {7'h00, monitor_update_request_q};
         `TPE_OFS_TX_MONITOR_UPDATE_STATUS: rdata_d = {7'h00, monitor_update_done_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `TPE_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end

endmodule // tpe_tx_errins

// ### tb/tpe_tx_errins_sva.sv
// Purpose: Port-level checks of the insertion and counter block.
// Assumes: One clock; read data one cycle after the read strobe.
// Notes: Internal state is judged only through its effect at the ports.
`timescale 1ns/1ps
module tpe_chk (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Transmit path
   input wire pkt_sent,
   input wire byte_sent,
   input wire auto_err_pkt,
   input wire manual_err,
   input wire irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========
   // Assertions
   unmapped_reads_zero_a: assert property (
      reg_rd && (reg_addr == 8'hc4 || reg_addr == 8'hcb ||
      reg_addr == 8'hcf || reg_addr == 8'hd5) |=> reg_rdata == 8'h00)
      else $error("unmapped or write-only read not zero");
   status_spare_zero_a: assert property (
      reg_rd && (reg_addr == 8'hc8 || reg_addr == 8'hc9 ||
      reg_addr == 8'hd7) |=> reg_rdata[7:1] == 7'h00)
      else $error("status spare bits not zero");
   read_data_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   auto_err_cause_a: assert property (auto_err_pkt |-> $past(pkt_sent))
      else $error("errored packet without a sent packet");
   manual_one_shot_a: assert property (manual_err |=> !manual_err)
      else $error("manual error longer than one cycle");
   manual_err_cause_a: assert property (manual_err |->
      $past(reg_wr && reg_addr == 8'hd4 && reg_wdata[0], 2))
      else $error("manual error without a write of one");
   irq_rise_cause_a: assert property ($rose(irq) |->
      $past(auto_err_pkt) || $past(reg_wr && reg_addr == 8'hca))
      else $error("interrupt rose without cause");
   irq_fall_cause_a: assert property ($fell(irq) |->
      $past(reg_rd && reg_addr == 8'hc9) || $past(reg_wr && reg_addr == 8'hca))
      else $error("interrupt fell without read or mask");
   latched_read_clears_a: assert property (
      reg_rd && reg_addr == 8'hc9 && !auto_err_pkt |=> !irq)
      else $error("interrupt stayed after latched read");
   auto_cov: cover property (auto_err_pkt);
   manual_cov: cover property (manual_err);
   irq_cov: cover property ($rose(irq));
endmodule // tpe_chk

bind tpe_tx_errins tpe_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pkt_sent(pkt_sent), .byte_sent(byte_sent), .auto_err_pkt(auto_err_pkt),
   .manual_err(manual_err), .irq(irq));

// ### tb/tpe_tx_errins_test.sv
// Purpose: Self-checking bench for the insertion and counter block.
// Assumes: Inputs driven on the falling edge; reads return next cycle.
// Notes: Counts are small so the run stays short.
`timescale 1ns/1ps
module tpe_tx_errins_test;
   reg ref_clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg pkt_sent = 1'b0;
   reg byte_sent = 1'b0;
   wire [7:0] reg_rdata;
   wire auto_err_pkt;
   wire manual_err;
   wire irq;
   integer miscompares = 0;
   integer tests_run = 0;
   integer auto_seen = 0;
   integer man_seen = 0;
   reg [7:0] rv;

   tpe_tx_errins DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_sent(pkt_sent),
      .byte_sent(byte_sent), .auto_err_pkt(auto_err_pkt), .manual_err(manual_err), .irq(irq));

   always #5 ref_clk = ~ref_clk;

   // Pulses are one cycle wide, so counting at the edge sees each once
   always @(posedge ref_clk) begin
      if (auto_err_pkt === 1'b1) auto_seen <= auto_seen + 1;
      if (manual_err === 1'b1) man_seen <= man_seen + 1;
   end

   // ==========
   // Helpers
   task chk(input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task rd(input [7:0] a);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      rv = reg_rdata;
   endtask
   task events(input integer np, input integer nb);
      integer i;
      for (i = 0; i < np || i < nb; i = i + 1) begin
         @(negedge ref_clk);
         pkt_sent = (i < np);
         byte_sent = (i < nb);
      end
      @(negedge ref_clk);
      pkt_sent = 1'b0;
      byte_sent = 1'b0;
   endtask
   task close_out;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ==========
   // Scenarios
   task reset_values;
      integer a;
      wr(8'hc8, 8'hff);
      wr(8'hc4, 8'h01);
      for (a = 8'hc4; a <= 8'hd7; a = a + 1) begin
         rd(a[7:0]);
         chk(rv, 8'h00);
      end
   endtask
   task update_counters;
      integer n;
      wr(8'hd6, 8'h01);
      rv = 8'h00;
      for (n = 0; n < 10 && rv[0] !== 1'b1; n = n + 1) rd(8'hd7);
      chk(rv, 8'h01);
      wr(8'hd6, 8'h00);
      rd(8'hd7);
      chk(rv, 8'h00);
   endtask
   task check_counters(input [23:0] ep, input [31:0] eb);
      integer k;
      for (k = 0; k < 3; k = k + 1) begin
         rd(8'hcc + k[7:0]);
         chk(rv, ep[8*k +: 8]);
      end
      for (k = 0; k < 4; k = k + 1) begin
         rd(8'hd0 + k[7:0]);
         chk(rv, eb[8*k +: 8]);
      end
   endtask
   task counter_test;
      events(5, 300);
      check_counters(24'h0, 32'h0);
      update_counters;
      check_counters(24'd5, 32'd300);
      events(2, 7);
      update_counters;
      check_counters(24'd2, 32'd7);
   endtask
   task auto_run(input [7:0] total, input [7:0] rate, input integer np, input integer ne,
      input [7:0] fin);
      integer base;
      wr(8'hc6, total);
      wr(8'hc7, rate);
      wr(8'hca, 8'h01);
      wr(8'hc4, 8'h01);
      base = auto_seen;
      events(np, 0);
      @(negedge ref_clk);
      chk(auto_seen - base, ne);
      rd(8'hc8);
      chk(rv, fin);
      chk(irq, fin[0]);
      wr(8'hca, 8'h00);
      chk(irq, 1'b0);
      wr(8'hca, 8'h01);
      rd(8'hc9);
      chk(rv, fin);
      rd(8'hc9);
      chk(rv, 8'h00);
      chk(irq, 1'b0);
      wr(8'hc6, 8'h00);
      wr(8'hc7, 8'h00);
      rd(8'hc8);
      chk(rv, 8'h00);
      wr(8'hc4, 8'h00);
   endtask
   task manual_test;
      wr(8'hc7, 8'h00);
      wr(8'hd4, 8'h01);
      wr(8'hd4, 8'h00);
      chk(man_seen, 0);
      wr(8'hc7, 8'h80);
      wr(8'hd4, 8'h01);
      wr(8'hd4, 8'h01);
      wr(8'hd4, 8'h00);
      wr(8'hd4, 8'h01);
      repeat (3) @(negedge ref_clk);
      chk(man_seen, 2);
      wr(8'hd4, 8'h00);
      wr(8'hc7, 8'h00);
   endtask

   initial begin
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      reset_values;
      counter_test;
      auto_run(8'h02, 8'h02, 6, 2, 8'h01);
      auto_run(8'h00, 8'h03, 7, 1, 8'h01);
      auto_run(8'hff, 8'h11, 25, 2, 8'h00);
      auto_run(8'h01, 8'h30, 4, 0, 8'h00);
      manual_test;
      close_out;
   end

   // Whole run needs a few hundred cycles; this is ample margin
   initial begin
      #200000;
      miscompares = miscompares + 1;
      close_out;
   end
endmodule // tpe_tx_errins_test
